// >>> oja_pkg.sv
// shared constants and types for the operand and jump addressing block
package oja_pkg;

  localparam int PC_W = 15;
  localparam int DATA_W = 8;
  localparam logic [14:0] PC_RESET = 15'h0000;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [7:0] SP_RESET = 8'h00;
  localparam logic [7:0] SP_STEP = 8'h02;
  localparam logic [14:0] REL_BIAS = 15'h0001;
  localparam logic [14:0] NEXT_BYTE = 15'h0001;
  localparam logic [3:0] REG_WINDOW = 4'hf;
  localparam logic [7:0] ADDR_X = 8'hfc;
  localparam logic [7:0] ADDR_SP = 8'hfd;
  localparam logic [7:0] ADDR_B = 8'hfe;
  localparam logic [3:0] BCD_MAX = 4'h9;
  localparam logic [7:0] BCD_LOW_ADJ = 8'h06;
  localparam logic [7:0] BCD_HIGH_ADJ = 8'h60;

  typedef enum logic [3:0] {
    OP_SEQ, OP_LD_IND, OP_LD_IMM, OP_LD_SHORT, OP_TABLE_LOAD,
    OP_JUMP_REL, OP_JUMP_ABS, OP_JUMP_LONG, OP_TABLE_JUMP, OP_VECTOR,
    OP_CALL, OP_RET, OP_RET_SKIP, OP_RET_INT, OP_TEST, OP_ALU
  } oja_op_e;

  typedef enum logic [1:0] {PM_NONE, PM_INC, PM_DEC} oja_pmod_e;

  typedef enum logic [3:0] {
    ALU_ADD, ALU_ADC, ALU_SUB, ALU_SUBC, ALU_INC, ALU_DEC,
    ALU_DECIMAL, ALU_CLR, ALU_SC, ALU_RC
  } oja_alu_e;

endpackage : oja_pkg

// >>> oja_pointer.sv
// one memory-mapped 8-bit pointer register with load and post-modify
`timescale 1ns/100ps
`default_nettype none
module oja_pointer
  import oja_pkg::*;
#(
  parameter int W = 8,
  parameter logic [7:0] RESET = PTR_RESET
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  // control
  input wire logic load,
  input wire logic [W-1:0] loadVal,
  input wire logic modify,
  input wire logic decrement,
  // value
  output logic [W-1:0] val
);
  logic [W-1:0] next_val;

  // load wins over modify; step wraps modulo 2**W and touches nothing else
  always_comb begin
    next_val = val;
    if (load) begin
      next_val = loadVal;
    end else if (modify) begin
      next_val = decrement ? val - W'(1) : val + W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      val <= W'(RESET);
    end else if (ce) begin
      val <= next_val;
    end
  end
endmodule : oja_pointer
`default_nettype wire

// >>> oja_alu.sv
// accumulator arithmetic: add, subtract, step, decimal correct, carry ops
`timescale 1ns/100ps
`default_nettype none
module oja_alu
  import oja_pkg::*;
(
  // request
  input wire oja_alu_e func,
  input wire logic [7:0] acc,
  input wire logic [7:0] operand,
  input wire logic carry,
  input wire logic halfCarry,
  // result
  output logic [7:0] result,
  output logic carryOut,
  output logic halfCarryOut
);
  logic sub;
  logic cin;
  logic [7:0] b;
  logic [8:0] sum;
  logic [4:0] half;

  always_comb begin
    sub = (func == ALU_SUB) || (func == ALU_SUBC);
    b = sub ? ~operand : operand;
    // carry set means no borrow on subtraction
    cin = (func == ALU_ADC || func == ALU_SUBC) ? carry : (func == ALU_SUB);
    sum = {1'b0, acc} + {1'b0, b} + {8'h00, cin};
    half = {1'b0, acc[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    result = acc;
    carryOut = carry;
    halfCarryOut = halfCarry;
    case (func)
      ALU_ADD, ALU_SUB: begin
        result = sum[7:0];
      end
      ALU_ADC, ALU_SUBC: begin
        result = sum[7:0];
        carryOut = sum[8];
        halfCarryOut = half[4];
      end
      ALU_INC: result = acc + 8'h01;
      ALU_DEC: result = acc - 8'h01;
      ALU_DECIMAL: begin
        result = acc + (((acc[3:0] > BCD_MAX) || halfCarry) ? BCD_LOW_ADJ : 8'h00)
                     + (((acc[7:4] > BCD_MAX) || carry) ? BCD_HIGH_ADJ : 8'h00);
        carryOut = carry || (acc[7:4] > BCD_MAX);
      end
      ALU_CLR: result = 8'h00;
      ALU_SC: carryOut = 1'b1;
      ALU_RC: carryOut = 1'b0;
      default: result = acc;
    endcase
  end
endmodule : oja_alu
`default_nettype wire

// >>> oja_addr_flow.sv
// operand addressing and program-flow unit of the 8-bit core
`timescale 1ns/100ps
`default_nettype none
module oja_addr_flow
  import oja_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  // decoded instruction
  input wire logic opValid,
  input wire oja_op_e opCode,
  input wire logic [1:0] instrLen,
  input wire logic ptrSel,
  input wire oja_pmod_e postMod,
  input wire logic [3:0] imm4,
  input wire logic [5:0] disp6,
  input wire logic [11:0] addr12,
  input wire logic [14:0] addr15,
  input wire oja_alu_e aluFunc,
  input wire logic [7:0] aluOperand,
  input wire logic testTrue,
  // program memory
  output logic progReq,
  output logic [14:0] progAddr,
  input wire logic progAck,
  input wire logic [7:0] progData,
  // data memory
  output logic dataReq,
  output logic [7:0] dataAddr,
  input wire logic dataAck,
  // register window writes
  input wire logic regWr,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  // stack
  output logic stackPush,
  output logic stackPop,
  output logic [7:0] stackAddr,
  output logic [14:0] stackWrData,
  input wire logic stackAck,
  input wire logic [14:0] stackRdData,
  // core state
  output logic [14:0] pc,
  output logic [7:0] acc,
  output logic carry,
  output logic halfCarry,
  output logic [7:0] ptrB,
  output logic [7:0] ptrX,
  output logic [7:0] sp,
  output logic skipNext,
  output logic opDone,
  output logic intReturn,
  output logic busy
);
  typedef enum logic [2:0] {ST_IDLE, ST_PWAIT, ST_VWAIT, ST_DWAIT, ST_SWAIT} oja_state_e;

  oja_state_e state, next_state;
  oja_op_e curOp, next_curOp;
  logic [1:0] curLen, next_curLen;
  logic curPtr, next_curPtr;
  oja_pmod_e curMod, next_curMod;
  logic [7:0] vecHi, next_vecHi;
  logic [14:0] next_pc, next_progAddr, next_stackWrData;
  logic [7:0] next_acc, next_dataAddr, next_stackAddr, next_sp;
  logic next_carry, next_halfCarry, next_skipNext, next_opDone, next_intReturn;
  logic next_progReq, next_dataReq, next_stackPush, next_stackPop;
  logic bLoad, xLoad, bMod, xMod, ptrDec;
  logic [7:0] bVal, xVal;
  logic [7:0] aluResult;
  logic aluCarry, aluHalf;
  logic [14:0] seqPc, curSeqPc;
  logic take;

  ////////////////////////////////////////////////////////////////////////
  oja_pointer #(.W(8), .RESET(PTR_RESET)) u_ptr_b (
    .clk(clk), .sys_rst(sys_rst), .ce(ce),
    .load(bLoad), .loadVal(bVal), .modify(bMod), .decrement(ptrDec), .val(ptrB)
  );
  oja_pointer #(.W(8), .RESET(PTR_RESET)) u_ptr_x (
    .clk(clk), .sys_rst(sys_rst), .ce(ce),
    .load(xLoad), .loadVal(xVal), .modify(xMod), .decrement(ptrDec), .val(ptrX)
  );
  oja_alu u_alu (
    .func(aluFunc), .acc(acc), .operand(aluOperand), .carry(carry),
    .halfCarry(halfCarry), .result(aluResult), .carryOut(aluCarry),
    .halfCarryOut(aluHalf)
  );

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    take = (state == ST_IDLE) && opValid;
    seqPc = pc + {13'h0000, instrLen};
    curSeqPc = pc + {13'h0000, curLen};
    next_state = state;
    next_curOp = curOp;
    next_curLen = curLen;
    next_curPtr = curPtr;
    next_curMod = curMod;
    next_vecHi = vecHi;
    next_pc = pc;
    next_acc = acc;
    next_carry = carry;
    next_halfCarry = halfCarry;
    next_sp = sp;
    next_skipNext = skipNext;
    next_opDone = 1'b0;
    next_intReturn = 1'b0;
    // requests hold until acknowledged
    next_progReq = progReq && !progAck;
    next_progAddr = progAddr;
    next_dataReq = dataReq && !dataAck;
    next_dataAddr = dataAddr;
    next_stackPush = stackPush && !stackAck;
    next_stackPop = stackPop && !stackAck;
    next_stackAddr = stackAddr;
    next_stackWrData = stackWrData;
    bLoad = 1'b0;
    xLoad = 1'b0;
    bVal = regWrData;
    xVal = regWrData;
    bMod = 1'b0;
    xMod = 1'b0;
    ptrDec = (curMod == PM_DEC);
    // register window writes; instruction loads below take priority
    if (regWr && regAddr[7:4] == REG_WINDOW) begin
      bLoad = (regAddr == ADDR_B);
      xLoad = (regAddr == ADDR_X);
      if (regAddr == ADDR_SP) begin
        next_sp = regWrData;
      end
    end
    case (state)
      ST_IDLE: begin
        if (take && skipNext) begin
          next_pc = seqPc;
          next_skipNext = 1'b0;
          next_opDone = 1'b1;
        end else if (take) begin
          next_curOp = opCode;
          next_curLen = instrLen;
          next_curPtr = ptrSel;
          next_curMod = postMod;
          next_opDone = 1'b1;
          next_pc = seqPc;
          case (opCode)
            OP_LD_IND: begin
              next_dataAddr = ptrSel ? ptrX : ptrB;
              next_dataReq = 1'b1;
              next_opDone = 1'b0;
              next_pc = pc;
              next_state = ST_DWAIT;
            end
            OP_LD_IMM: begin
              next_progAddr = pc + NEXT_BYTE;
              next_progReq = 1'b1;
              next_opDone = 1'b0;
              next_pc = pc;
              next_state = ST_PWAIT;
            end
            OP_LD_SHORT: begin
              bLoad = 1'b1;
              bVal = {4'h0, imm4};
            end
            OP_TABLE_LOAD, OP_TABLE_JUMP: begin
              next_progAddr = {pc[14:8], acc};
              next_progReq = 1'b1;
              next_opDone = 1'b0;
              next_pc = pc;
              next_state = ST_PWAIT;
            end
            OP_VECTOR: begin
              next_progAddr = addr15;
              next_progReq = 1'b1;
              next_opDone = 1'b0;
              next_pc = pc;
              next_state = ST_PWAIT;
            end
            OP_JUMP_REL: next_pc = pc + {{9{disp6[5]}}, disp6} + REL_BIAS;
            OP_JUMP_ABS: next_pc = {pc[14:12], addr12};
            OP_JUMP_LONG: next_pc = addr15;
            OP_CALL: begin
              next_stackPush = 1'b1;
              next_stackAddr = sp;
              next_stackWrData = seqPc;
              next_sp = sp - SP_STEP;
              next_pc = addr15;
              next_opDone = 1'b0;
              next_state = ST_SWAIT;
            end
            OP_RET, OP_RET_SKIP, OP_RET_INT: begin
              next_stackPop = 1'b1;
              next_stackAddr = sp + SP_STEP;
              next_opDone = 1'b0;
              next_pc = pc;
              next_state = ST_SWAIT;
            end
            OP_TEST: next_skipNext = !testTrue;
            OP_ALU: begin
              next_acc = aluResult;
              next_carry = aluCarry;
              next_halfCarry = aluHalf;
            end
            default: next_pc = seqPc;
          endcase
        end
      end
      ST_PWAIT: begin
        if (progAck) begin
          next_opDone = 1'b1;
          next_state = ST_IDLE;
          case (curOp)
            OP_TABLE_JUMP: next_pc = {pc[14:8], progData};
            OP_VECTOR: begin
              next_vecHi = progData;
              next_progAddr = progAddr + NEXT_BYTE;
              next_progReq = 1'b1;
              next_opDone = 1'b0;
              next_state = ST_VWAIT;
            end
            default: begin
              // table load leaves pc on the next instruction
              next_acc = progData;
              next_pc = curSeqPc;
            end
          endcase
        end
      end
      ST_VWAIT: begin
        if (progAck) begin
          next_pc = {vecHi[6:0], progData};
          next_opDone = 1'b1;
          next_state = ST_IDLE;
        end
      end
      ST_DWAIT: begin
        if (dataAck) begin
          bMod = (curMod != PM_NONE) && !curPtr;
          xMod = (curMod != PM_NONE) && curPtr;
          next_pc = curSeqPc;
          next_opDone = 1'b1;
          next_state = ST_IDLE;
        end
      end
      ST_SWAIT: begin
        if (stackAck) begin
          if (curOp != OP_CALL) begin
            next_pc = stackRdData;
            next_sp = sp + SP_STEP;
            next_skipNext = (curOp == OP_RET_SKIP);
            next_intReturn = (curOp == OP_RET_INT);
          end
          next_opDone = 1'b1;
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= ST_IDLE;
      curOp <= OP_SEQ;
      curLen <= 2'h0;
      curPtr <= 1'b0;
      curMod <= PM_NONE;
      vecHi <= 8'h00;
      pc <= PC_RESET;
      acc <= 8'h00;
      carry <= 1'b0;
      halfCarry <= 1'b0;
      sp <= SP_RESET;
      skipNext <= 1'b0;
      opDone <= 1'b0;
      intReturn <= 1'b0;
      progReq <= 1'b0;
      progAddr <= 15'h0000;
      dataReq <= 1'b0;
      dataAddr <= 8'h00;
      stackPush <= 1'b0;
      stackPop <= 1'b0;
      stackAddr <= 8'h00;
      stackWrData <= 15'h0000;
      busy <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      curOp <= next_curOp;
      curLen <= next_curLen;
      curPtr <= next_curPtr;
      curMod <= next_curMod;
      vecHi <= next_vecHi;
      pc <= next_pc;
      acc <= next_acc;
      carry <= next_carry;
      halfCarry <= next_halfCarry;
      sp <= next_sp;
      skipNext <= next_skipNext;
      opDone <= next_opDone;
      intReturn <= next_intReturn;
      progReq <= next_progReq;
      progAddr <= next_progAddr;
      dataReq <= next_dataReq;
      dataAddr <= next_dataAddr;
      stackPush <= next_stackPush;
      stackPop <= next_stackPop;
      stackAddr <= next_stackAddr;
      stackWrData <= next_stackWrData;
      busy <= (next_state != ST_IDLE);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_take(oja_op_e o);
    ce && state == ST_IDLE && opValid && !skipNext && opCode == o;
  endsequence
  sequence s_ack_dwait;
    ce && state == ST_DWAIT && dataAck;
  endsequence

  property p_ind_addr;
    s_take(OP_LD_IND) |=> dataReq && dataAddr == ($past(ptrSel) ? $past(ptrX) : $past(ptrB));
  endproperty
  a_ind_addr: assert property (p_ind_addr) else $error("indirect address wrong");

  property p_post_inc_b;
    s_ack_dwait ##0 (curMod == PM_INC && !curPtr) |=> ptrB == $past(ptrB) + 8'h01;
  endproperty
  a_post_inc_b: assert property (p_post_inc_b) else $error("post increment wrong");

  property p_post_dec_x;
    s_ack_dwait ##0 (curMod == PM_DEC && curPtr) |=> ptrX == $past(ptrX) - 8'h01 && ptrB == $past(ptrB);
  endproperty
  a_post_dec_x: assert property (p_post_dec_x) else $error("post decrement wrong");

  property p_imm_addr;
    s_take(OP_LD_IMM) |=> progReq && progAddr == $past(pc) + NEXT_BYTE;
  endproperty
  a_imm_addr: assert property (p_imm_addr) else $error("immediate address wrong");

  property p_short_load;
    s_take(OP_LD_SHORT) |=> ptrB == {4'h0, $past(imm4)};
  endproperty
  a_short_load: assert property (p_short_load) else $error("short load wrong");

  property p_table_addr;
    s_take(OP_TABLE_LOAD) |=> progReq && progAddr == {$past(pc[14:8]), $past(acc)} && pc == $past(pc);
  endproperty
  a_table_addr: assert property (p_table_addr) else $error("table address wrong");

  property p_rel;
    s_take(OP_JUMP_REL) |=> pc == $past(pc) + {{9{$past(disp6[5])}}, $past(disp6)} + REL_BIAS;
  endproperty
  a_rel: assert property (p_rel) else $error("relative jump wrong");

  property p_abs;
    s_take(OP_JUMP_ABS) |=> pc == {$past(pc[14:12]), $past(addr12)};
  endproperty
  a_abs: assert property (p_abs) else $error("absolute jump wrong");

  property p_long;
    s_take(OP_JUMP_LONG) |=> pc == $past(addr15) && opDone;
  endproperty
  a_long: assert property (p_long) else $error("long jump wrong");

  property p_skip;
    ce && state == ST_IDLE && opValid && skipNext |=>
      pc == $past(pc) + {13'h0000, $past(instrLen)} && !skipNext && acc == $past(acc) && !busy;
  endproperty
  a_skip: assert property (p_skip) else $error("skipped instruction had effect");

  property p_call;
    s_take(OP_CALL) |=> stackPush && stackWrData == $past(pc) + {13'h0000, $past(instrLen)}
      && pc == $past(addr15) && sp == $past(sp) - SP_STEP;
  endproperty
  a_call: assert property (p_call) else $error("call push wrong");

endmodule : oja_addr_flow
`default_nettype wire

// >>> operand_and_jump_addressing_tb.sv
// self-checking bench for the operand and jump addressing unit
`timescale 1ns/100ps
`default_nettype none
module operand_and_jump_addressing_tb
  import oja_pkg::*;
;
  logic clk, sysRst, ce, opValid, ptrSel, testTrue, progAck, dataAck, regWr, stackAck;
  oja_op_e opCode;
  oja_pmod_e postMod;
  oja_alu_e aluFunc;
  logic [1:0] instrLen;
  logic [3:0] imm4;
  logic [5:0] disp6;
  logic [11:0] addr12;
  logic [14:0] addr15, stackRdData, progAddr, stackWrData, pc;
  logic [7:0] aluOperand, progData, regAddr, regWrData, dataAddr, stackAddr;
  logic [7:0] acc, ptrB, ptrX, sp;
  logic progReq, dataReq, stackPush, stackPop, carry, halfCarry;
  logic skipNext, opDone, intReturn, busy;
  int errCount, totalChecks;

  oja_addr_flow dut (
    .clk(clk), .sys_rst(sysRst), .ce(ce), .opValid(opValid), .opCode(opCode),
    .instrLen(instrLen), .ptrSel(ptrSel), .postMod(postMod), .imm4(imm4), .disp6(disp6),
    .addr12(addr12), .addr15(addr15), .aluFunc(aluFunc), .aluOperand(aluOperand),
    .testTrue(testTrue), .progReq(progReq), .progAddr(progAddr), .progAck(progAck),
    .progData(progData), .dataReq(dataReq), .dataAddr(dataAddr), .dataAck(dataAck),
    .regWr(regWr), .regAddr(regAddr), .regWrData(regWrData), .stackPush(stackPush),
    .stackPop(stackPop), .stackAddr(stackAddr), .stackWrData(stackWrData),
    .stackAck(stackAck), .stackRdData(stackRdData), .pc(pc), .acc(acc), .carry(carry),
    .halfCarry(halfCarry), .ptrB(ptrB), .ptrX(ptrX), .sp(sp), .skipNext(skipNext),
    .opDone(opDone), .intReturn(intReturn), .busy(busy)
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

////////////////////////////////////////
  task automatic endOfTest();
    $display("checks %0d mismatches %0d", totalChecks, errCount);
    if (errCount == 0 && totalChecks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : endOfTest

  task automatic tally(input logic ok, input logic [14:0] got, input logic [14:0] exp);
    totalChecks++;
    if (!ok) begin
      errCount++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : tally

  task automatic chkPc(input logic [14:0] got, input logic [14:0] exp);
    tally(got === exp, got, exp);
  endtask : chkPc

  task automatic chkByte(input logic [7:0] got, input logic [7:0] exp);
    tally(got === exp, {7'h00, got}, {7'h00, exp});
  endtask : chkByte

  task automatic chkBit(input logic got, input logic exp);
    tally(got === exp, {14'h0000, got}, {14'h0000, exp});
  endtask : chkBit

////////////////////////////////////////
  // one field value is spread over every operand input of the op
  task automatic issue(input oja_op_e op, input logic [1:0] len, input logic [14:0] f);
    // one idle edge first, so valid never flips twice in one step
    @(negedge clk);
    opValid = 1'b1;
    opCode = op;
    instrLen = len;
    addr15 = f;
    addr12 = f[11:0];
    disp6 = f[5:0];
    imm4 = f[3:0];
    aluOperand = f[7:0];
    @(negedge clk);
    opValid = 1'b0;
  endtask : issue

  task automatic waitDone();
    int n = 0;
    while (opDone !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    chkBit(opDone, 1'b1);
  endtask : waitDone

  task automatic waitReq();
    int n = 0;
    while ((progReq | dataReq | stackPush | stackPop) !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
  endtask : waitReq

  // released read data is inverted so a stale byte cannot pass
  task automatic serveProg(input logic [14:0] expAddr, input logic [7:0] data);
    waitReq();
    chkBit(progReq, 1'b1);
    chkPc(progAddr, expAddr);
    progAck = 1'b1;
    progData = data;
    @(negedge clk);
    progAck = 1'b0;
    progData = ~data;
  endtask : serveProg

  task automatic serveStack(input logic push, input logic [14:0] wr, input logic [14:0] rd);
    waitReq();
    chkBit(stackPush, push);
    chkBit(stackPop, !push);
    chkByte(stackAddr, 8'h6f);
    if (push) begin
      chkPc(stackWrData, wr);
    end
    stackAck = 1'b1;
    stackRdData = rd;
    @(negedge clk);
    stackAck = 1'b0;
    stackRdData = ~rd;
  endtask : serveStack

  task automatic winWr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    regWr = 1'b1;
    regAddr = a;
    regWrData = d;
    @(negedge clk);
    regWr = 1'b0;
  endtask : winWr

  task automatic ldInd(input logic sel, input oja_pmod_e pm, input logic [7:0] expAddr);
    ptrSel = sel;
    postMod = pm;
    issue(OP_LD_IND, 2'd1, 15'h0000);
    waitReq();
    chkBit(dataReq & busy, 1'b1);
    chkByte(dataAddr, expAddr);
    dataAck = 1'b1;
    @(negedge clk);
    dataAck = 1'b0;
    waitDone();
  endtask : ldInd

  task automatic ldImm(input logic [7:0] d);
    logic [14:0] p = pc;
    issue(OP_LD_IMM, 2'd2, 15'h0000);
    serveProg(p + NEXT_BYTE, d);
    waitDone();
    chkByte(acc, d);
  endtask : ldImm

  task automatic jumpLong(input logic [14:0] t);
    issue(OP_JUMP_LONG, 2'd3, t);
    waitDone();
    chkPc(pc, t);
  endtask : jumpLong

  task automatic rel(input logic [5:0] d, input logic [14:0] off);
    logic [14:0] p = pc;
    issue(OP_JUMP_REL, 2'd1, {9'h000, d});
    waitDone();
    chkPc(pc, p + off);
  endtask : rel

  // the skipped op is a long jump, so obeying it would move pc far
  task automatic skipped();
    logic [14:0] p = pc;
    logic [7:0] a = acc;
    chkBit(skipNext, 1'b1);
    issue(OP_JUMP_LONG, 2'd3, 15'h7777);
    waitDone();
    chkPc(pc, p + 15'h0003);
    chkByte(acc, a);
    chkBit(skipNext, 1'b0);
  endtask : skipped

  task automatic callRet(input oja_op_e r);
    logic [14:0] p = pc;
    issue(OP_CALL, 2'd2, 15'h2345);
    serveStack(1'b1, p + 15'h0002, 15'h0000);
    waitDone();
    chkPc(pc, 15'h2345);
    chkByte(sp, 8'h6d);
    issue(r, 2'd1, 15'h0000);
    serveStack(1'b0, 15'h0000, p + 15'h0002);
    waitDone();
    chkBit(intReturn, r == OP_RET_INT);
    chkPc(pc, p + 15'h0002);
    chkByte(sp, 8'h6f);
  endtask : callRet

  task automatic aluStep(input oja_alu_e f, input logic [7:0] o, input logic [7:0] a,
                         input logic c);
    aluFunc = f;
    issue(OP_ALU, 2'd1, {7'h00, o});
    waitDone();
    chkByte(acc, a);
    chkBit(carry, c);
  endtask : aluStep

////////////////////////////////////////
  task automatic tReset();
    chkPc(pc, PC_RESET);
    chkByte(sp, SP_RESET);
    chkByte(ptrB, PTR_RESET);
    chkByte(ptrX, PTR_RESET);
    chkBit(busy | progReq | dataReq | stackPush | stackPop, 1'b0);
  endtask : tReset

  task automatic tPointers();
    winWr(ADDR_B, 8'h05);
    winWr(ADDR_X, 8'hff);
    winWr(ADDR_SP, 8'h6f);
    chkByte(ptrB, 8'h05);
    chkByte(ptrX, 8'hff);
    chkByte(sp, 8'h6f);
    ldInd(1'b0, PM_INC, 8'h05);
    chkByte(ptrB, 8'h06);
    ldInd(1'b1, PM_INC, 8'hff);
    chkByte(ptrX, 8'h00);
    ldInd(1'b0, PM_DEC, 8'h06);
    chkByte(ptrB, 8'h05);
    ldInd(1'b1, PM_DEC, 8'h00);
    chkByte(ptrX, 8'hff);
    chkByte(ptrB, 8'h05);
    chkByte(sp, 8'h6f);
    winWr(ADDR_B, 8'h12);
    issue(OP_LD_SHORT, 2'd1, 15'h0007);
    waitDone();
    chkByte(ptrB, 8'h07);
  endtask : tPointers

  task automatic tJumps();
    jumpLong(15'h3625);
    issue(OP_JUMP_ABS, 2'd2, 15'h0125);
    waitDone();
    chkPc(pc, 15'h3125);
    // displacement codes are biased by one: code zero gives offset one
    rel(6'h20, 15'h7fe1);
    rel(6'h1f, 15'h0020);
    rel(6'h09, 15'h000a);
  endtask : tJumps

  task automatic tTables();
    ldImm(8'h1f);
    jumpLong(15'h0435);
    issue(OP_TABLE_LOAD, 2'd1, 15'h0000);
    serveProg(15'h041f, 8'h25);
    waitDone();
    chkByte(acc, 8'h25);
    chkPc(pc, 15'h0436);
    ldImm(8'h26);
    jumpLong(15'h01c4);
    issue(OP_TABLE_JUMP, 2'd1, 15'h0000);
    serveProg(15'h0126, 8'h32);
    waitDone();
    chkPc(pc, 15'h0132);
    issue(OP_VECTOR, 2'd1, 15'h0200);
    serveProg(15'h0200, 8'h8a);
    @(negedge clk);
    serveProg(15'h0201, 8'h55);
    waitDone();
    chkPc(pc, 15'h0a55);
  endtask : tTables

  task automatic tFlow();
    callRet(OP_RET);
    callRet(OP_RET_INT);
    callRet(OP_RET_SKIP);
    skipped();
    testTrue = 1'b0;
    issue(OP_TEST, 2'd1, 15'h0000);
    waitDone();
    skipped();
    testTrue = 1'b1;
    issue(OP_TEST, 2'd1, 15'h0000);
    waitDone();
    chkBit(skipNext, 1'b0);
    jumpLong(15'h0300);
  endtask : tFlow

  // frozen clock enable must swallow an op; then a reset in mid-run
  task automatic tFreeze();
    logic [14:0] p = pc;
    @(negedge clk);
    ce = 1'b0;
    issue(OP_JUMP_LONG, 2'd3, 15'h1111);
    chkPc(pc, p);
    chkBit(opDone | busy, 1'b0);
    ce = 1'b1;
    sysRst = 1'b1;
    @(negedge clk);
    sysRst = 1'b0;
    tReset();
  endtask : tFreeze

  task automatic tAlu();
    aluStep(ALU_CLR, 8'h00, 8'h00, 1'b0);
    aluStep(ALU_SC, 8'h00, 8'h00, 1'b1);
    aluStep(ALU_RC, 8'h00, 8'h00, 1'b0);
    aluStep(ALU_INC, 8'h00, 8'h01, 1'b0);
    aluStep(ALU_DEC, 8'h00, 8'h00, 1'b0);
    aluStep(ALU_ADD, 8'h45, 8'h45, 1'b0);
    aluStep(ALU_ADC, 8'h3c, 8'h81, 1'b0);
    chkBit(halfCarry, 1'b1);
    aluStep(ALU_DECIMAL, 8'h00, 8'h87, 1'b0);
    aluStep(ALU_SUB, 8'h07, 8'h80, 1'b0);
    aluStep(ALU_SC, 8'h00, 8'h80, 1'b1);
    aluStep(ALU_SUBC, 8'h01, 8'h7f, 1'b1);
  endtask : tAlu

////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk);
    errCount++;
    endOfTest();
  end

  initial begin
    errCount = 0;
    totalChecks = 0;
    sysRst = 1'b1;
    ce = 1'b1;
    opValid = 1'b0;
    opCode = OP_SEQ;
    instrLen = 2'd1;
    ptrSel = 1'b0;
    postMod = PM_NONE;
    imm4 = 4'h0;
    disp6 = 6'h00;
    addr12 = 12'h000;
    addr15 = 15'h0000;
    aluFunc = ALU_ADD;
    aluOperand = 8'h00;
    testTrue = 1'b0;
    progAck = 1'b0;
    progData = 8'h00;
    dataAck = 1'b0;
    regWr = 1'b0;
    regAddr = 8'h00;
    regWrData = 8'h00;
    stackAck = 1'b0;
    stackRdData = 15'h0000;
    repeat (10) @(negedge clk);
    sysRst = 1'b0;
    tReset();
    tPointers();
    tJumps();
    tTables();
    tFlow();
    tFreeze();
    tAlu();
    endOfTest();
  end
endmodule : operand_and_jump_addressing_tb
`default_nettype wire
